// *** spsel_pkg.sv ***
// package of register map, field layout and codes for the strobe and pattern pin select
package spsel_pkg;
  // register addresses (byte addresses on the internal bus)
  localparam logic [25:0] SPSEL_ADDR_STROBE_SEL = 26'h5ffffee;
  localparam logic [25:0] SPSEL_ADDR_PATTERN_MODE = 26'h5fffff0;
  localparam logic [25:0] SPSEL_ADDR_PORTB_CTRL2 = 26'h5ffffc0;
  // field positions
  localparam int SPSEL_HI_STROBE_LSB = 14;
  localparam int SPSEL_LO_STROBE_LSB = 12;
  localparam int SPSEL_PB0_FUNC_LSB = 0;
  // reset values
  localparam logic [15:0] SPSEL_RST_STROBE_SEL = 16'h5fff;
  localparam logic [7:0] SPSEL_RST_PATTERN_MODE = 8'hf0;
  localparam logic [15:0] SPSEL_RST_PORTB_CTRL2 = 16'h0000;
  // writable masks; other bits read as one, except in port b control where they read zero
  localparam logic [15:0] SPSEL_MASK_STROBE_SEL = 16'hf000;
  localparam logic [7:0] SPSEL_MASK_PATTERN_MODE = 8'h0f;
  localparam logic [15:0] SPSEL_MASK_PORTB_CTRL2 = 16'h0003;
  // port b bit 0 function codes
  typedef enum logic [1:0]
  {
    SPSEL_PB0_GPIO = 2'b00,
    SPSEL_PB0_RSVD = 2'b01,
    SPSEL_PB0_TIMER = 2'b10,
    SPSEL_PB0_PATTERN = 2'b11
  } spsel_pb0_e;
  // shared strobe pin codes
  typedef enum logic [1:0]
  {
    SPSEL_STB_RSVD0 = 2'b00,
    SPSEL_STB_CHIPSEL = 2'b01,
    SPSEL_STB_COLSTROBE = 2'b10,
    SPSEL_STB_RSVD3 = 2'b11
  } spsel_stb_e;
endpackage : spsel_pkg

// *** spsel_top.sv ***
// strobe and pattern pin select: registers, pin muxes and non-overlap pattern groups
`timescale 1ns/1ps
`default_nettype none

// register port behaviour
// - one plain 16-bit port, exact byte-address match per register
// - a write strobe lands in the register at the edge that samples it
// - a read strobe returns data in the following cycle only
// - read data is zero in every other cycle and for unmapped addresses
// - byte and long accesses are not modelled; software uses 16-bit words
// - the pattern mode register sits in the low byte of the data word
// - writes to unmapped addresses are dropped without any side effect

// unused bits
// - strobe select bits 11:0 are forced back to ones on every write
// - pattern mode bits 7:4 are forced back to ones on every write
// - port b control bits 15:2 are not implemented and read zero
// - masks and reset values live in the package, one name each

// port b bit 0 pin
// - code 00: gpio drive and enable pass to the pin
// - code 01: reserved; pin released, output held low
// - code 10: timer 2 compare a drives, capture input sees the pin
// - code 11: pattern bit 0 drives, enable held high
// - the input path always passes two flops before any logic
// - gpio input sees the pin three cycles after it moves
// - timer capture input reads zero unless code 10 is selected
// - hazard: a reserved code releases the pin, so a pull is needed

// shared strobe pins
// - code 01 routes the chip select, which is the reset choice
// - code 10 routes the column address strobe of that byte lane
// - reserved codes 00 and 11 hold the pin inactive high
// - all strobe sources are active low and come from this clock
// - no synchroniser on strobes: the memory controller is on clk_sys
// - pins are registered, so a source reaches its pin one cycle late
// - limitation: that cycle of delay must be budgeted by the controller

// pattern groups
// - four groups of four bits, group g on bits 4g+3 to 4g
// - normal mode: compare a loads the next data of the group
// - non-overlap mode: compare a sets ones from the next data
// - non-overlap mode: compare b clears where the next data is zero
// - both matches in one cycle: set first, then clear
// - compare b alone leaves a normal-mode group untouched
// - pattern outputs are registered and follow the match by one edge
// - pattern bit 0 on the port b pin uses the same next value

// reset
// - asynchronous, active low, released on the system clock
// - registers return to their documented reset contents
// - pins released, strobe pins inactive high, pattern cleared
// - the first request may come at the first edge after release

// timing
// - every top output comes straight from a flop
// - register contents reach the pins one cycle after the write
// - no counters, no waits; the port never stalls the master

// trade-offs
// - exact address match keeps decode small, aliases are not decoded
// - reserved codes are made safe rather than trapped
// - the trigger source choice per group sits outside this block
module spsel_top
  import spsel_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [25:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // port b bit 0 sources
  input wire logic gpio_b0_out,
  input wire logic gpio_b0_oe,
  input wire logic timer2_compare_a_out,
  input wire logic timer2_compare_a_oe,
  // port b bit 0 pin
  input wire logic port_b_bit0_in,
  output logic port_b_bit0_out,
  output logic port_b_bit0_oe,
  output logic gpio_b0_in,
  output logic timer2_capture_a_in,
  // pattern engine: next data and compare matches per group
  input wire logic [15:0] pattern_next_data,
  input wire logic [3:0] group_compare_a,
  input wire logic [3:0] group_compare_b,
  output logic [15:0] pattern_out,
  // memory controller strobes
  input wire logic chip_select_1_n,
  input wire logic chip_select_3_n,
  input wire logic column_strobe_high_n,
  input wire logic column_strobe_low_n,
  output logic strobe_hi_pin_n,
  output logic strobe_lo_pin_n
);

  logic [15:0] port_b_control_2;
  logic [15:0] column_strobe_pin_select;
  logic [7:0] pattern_nonoverlap_mode;
  logic [15:0] next_port_b_control_2;
  logic [15:0] next_column_strobe_pin_select;
  logic [7:0] next_pattern_nonoverlap_mode;
  logic [15:0] next_reg_rdata;
  logic [15:0] pattern;
  logic [15:0] next_pattern;
  logic pb_in_s1;
  logic pb_in_s2;
  logic next_pb_out;
  logic next_pb_oe;
  logic next_hi;
  logic next_lo;
  spsel_pb0_e pb0_func;
  spsel_stb_e hi_func;
  spsel_stb_e lo_func;

  assign pb0_func = spsel_pb0_e'(port_b_control_2[SPSEL_PB0_FUNC_LSB +: 2]);
  assign hi_func = spsel_stb_e'(column_strobe_pin_select[SPSEL_HI_STROBE_LSB +: 2]);
  assign lo_func = spsel_stb_e'(column_strobe_pin_select[SPSEL_LO_STROBE_LSB +: 2]);

  // register writes and read mux
  always_comb
  begin
    next_port_b_control_2 = port_b_control_2;
    next_column_strobe_pin_select = column_strobe_pin_select;
    next_pattern_nonoverlap_mode = pattern_nonoverlap_mode;
    next_reg_rdata = 16'h0000;
    if (reg_wr && reg_addr == SPSEL_ADDR_PORTB_CTRL2)
    begin
      next_port_b_control_2 = (reg_wdata & SPSEL_MASK_PORTB_CTRL2)
        | (SPSEL_RST_PORTB_CTRL2 & ~SPSEL_MASK_PORTB_CTRL2);
    end
    else if (reg_wr && reg_addr == SPSEL_ADDR_STROBE_SEL)
    begin
      // unused bits forced back to ones
      next_column_strobe_pin_select = (reg_wdata & SPSEL_MASK_STROBE_SEL)
        | ~SPSEL_MASK_STROBE_SEL;
    end
    else if (reg_wr && reg_addr == SPSEL_ADDR_PATTERN_MODE)
    begin
      next_pattern_nonoverlap_mode = (reg_wdata[7:0] & SPSEL_MASK_PATTERN_MODE)
        | ~SPSEL_MASK_PATTERN_MODE;
    end
    if (reg_rd && reg_addr == SPSEL_ADDR_PORTB_CTRL2)
    begin
      next_reg_rdata = port_b_control_2;
    end
    else if (reg_rd && reg_addr == SPSEL_ADDR_STROBE_SEL)
    begin
      next_reg_rdata = column_strobe_pin_select;
    end
    else if (reg_rd && reg_addr == SPSEL_ADDR_PATTERN_MODE)
    begin
      next_reg_rdata = {8'h00, pattern_nonoverlap_mode};
    end
  end

  // register state
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_b_control_2 <= SPSEL_RST_PORTB_CTRL2;
      column_strobe_pin_select <= SPSEL_RST_STROBE_SEL;
      pattern_nonoverlap_mode <= SPSEL_RST_PATTERN_MODE;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      port_b_control_2 <= next_port_b_control_2;
      column_strobe_pin_select <= next_column_strobe_pin_select;
      pattern_nonoverlap_mode <= next_pattern_nonoverlap_mode;
      reg_rdata <= next_reg_rdata;
    end
  end

  // pattern groups: normal or non-overlap update
  always_comb
  begin
    next_pattern = pattern;
    for (int g = 0; g < 4; g++)
    begin
      if (!pattern_nonoverlap_mode[g])
      begin
        if (group_compare_a[g])
        begin
          next_pattern[g*4 +: 4] = pattern_next_data[g*4 +: 4];
        end
      end
      else
      begin
        // compare a raises ones, compare b drops zeros
        if (group_compare_a[g])
        begin
          next_pattern[g*4 +: 4] = next_pattern[g*4 +: 4]
            | pattern_next_data[g*4 +: 4];
        end
        if (group_compare_b[g])
        begin
          next_pattern[g*4 +: 4] = next_pattern[g*4 +: 4]
            & pattern_next_data[g*4 +: 4];
        end
      end
    end
  end

  // pin multiplexers from current register contents
  always_comb
  begin
    next_pb_out = gpio_b0_out;
    next_pb_oe = gpio_b0_oe;
    case (pb0_func)
      SPSEL_PB0_TIMER:
      begin
        next_pb_out = timer2_compare_a_out;
        next_pb_oe = timer2_compare_a_oe;
      end
      SPSEL_PB0_PATTERN:
      begin
        next_pb_out = next_pattern[0];
        next_pb_oe = 1'b1;
      end
      SPSEL_PB0_RSVD:
      begin
        next_pb_out = 1'b0; // reserved code leaves pin undriven
        next_pb_oe = 1'b0;
      end
      default:
      begin
        next_pb_out = gpio_b0_out;
        next_pb_oe = gpio_b0_oe;
      end
    endcase
    case (hi_func)
      SPSEL_STB_CHIPSEL: next_hi = chip_select_1_n;
      SPSEL_STB_COLSTROBE: next_hi = column_strobe_high_n;
      default: next_hi = 1'b1; // reserved: inactive high
    endcase
    case (lo_func)
      SPSEL_STB_CHIPSEL: next_lo = chip_select_3_n;
      SPSEL_STB_COLSTROBE: next_lo = column_strobe_low_n;
      default: next_lo = 1'b1;
    endcase
  end

  // registered pins and two-stage input synchroniser
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pattern <= 16'h0000;
      pb_in_s1 <= 1'b0;
      pb_in_s2 <= 1'b0;
      port_b_bit0_out <= 1'b0;
      port_b_bit0_oe <= 1'b0;
      gpio_b0_in <= 1'b0;
      timer2_capture_a_in <= 1'b0;
      pattern_out <= 16'h0000;
      strobe_hi_pin_n <= 1'b1;
      strobe_lo_pin_n <= 1'b1;
    end
    else
    begin
      pattern <= next_pattern;
      pb_in_s1 <= port_b_bit0_in;
      pb_in_s2 <= pb_in_s1;
      port_b_bit0_out <= next_pb_out;
      port_b_bit0_oe <= next_pb_oe;
      gpio_b0_in <= pb_in_s2;
      timer2_capture_a_in <= (pb0_func == SPSEL_PB0_TIMER) ? pb_in_s2 : 1'b0;
      pattern_out <= next_pattern;
      strobe_hi_pin_n <= next_hi;
      strobe_lo_pin_n <= next_lo;
    end
  end

endmodule : spsel_top
`default_nettype wire

// *** spsel_chk_sva.sv ***
// checker of register reads, strobe pins and pattern groups
`timescale 1ns/1ps
`default_nettype none
module spsel_chk
  import spsel_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [25:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // strobe sources and pins
  input wire logic chip_select_1_n,
  input wire logic chip_select_3_n,
  input wire logic column_strobe_high_n,
  input wire logic column_strobe_low_n,
  input wire logic strobe_hi_pin_n,
  input wire logic strobe_lo_pin_n,
  // pattern groups
  input wire logic [15:0] pattern_next_data,
  input wire logic [3:0] group_compare_a,
  input wire logic [3:0] group_compare_b,
  input wire logic [15:0] pattern_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // read data only after a read, unused bits as ones
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside a read");
  a_strobe_ones: assert property ($past(reg_rd) && $past(reg_addr) == SPSEL_ADDR_STROBE_SEL
    |-> reg_rdata[11:0] == 12'hfff) else $error("strobe select low bits");
  a_mode_ones: assert property ($past(reg_rd) && $past(reg_addr) == SPSEL_ADDR_PATTERN_MODE
    |-> reg_rdata[15:4] == 12'h00f) else $error("pattern mode high bits");
  // a strobe pin only goes low after one of its sources
  a_hi_source: assert property (!strobe_hi_pin_n |-> !$past(chip_select_1_n) ||
    !$past(column_strobe_high_n)) else $error("high strobe pin low");
  a_lo_source: assert property (!strobe_lo_pin_n |-> !$past(chip_select_3_n) ||
    !$past(column_strobe_low_n)) else $error("low strobe pin low");
  // pattern groups: group 0 moves only on matches, group 1 keeps compare a ones, group 2 only clears on compare b
  a_group_hold: assert property (!$past(group_compare_a[0] || group_compare_b[0])
    |-> pattern_out[3:0] == $past(pattern_out[3:0])) else $error("group 0 moved");
  a_cmpa_ones: assert property ($past(group_compare_a[1] && !group_compare_b[1])
    |-> (pattern_out[7:4] & $past(pattern_next_data[7:4])) == $past(pattern_next_data[7:4]))
    else $error("compare a lost ones");
  a_cmpb_clear: assert property ($past(group_compare_b[2] && !group_compare_a[2])
    |-> (pattern_out[11:8] & ~$past(pattern_out[11:8])) == 4'h0)
    else $error("compare b set a bit");
  // main scenarios
  c_hi_low: cover property (!strobe_hi_pin_n && !$past(column_strobe_high_n));
  c_lo_low: cover property (!strobe_lo_pin_n);
  c_cmpb: cover property ($past(group_compare_b[2]) && pattern_out[11:8] != $past(pattern_out[11:8]));
endmodule : spsel_chk
bind spsel_top spsel_chk u_chk (.*);
`default_nettype wire

// *** spsel_far.sv ***
// far-side model of the port b bit 0 pin
`timescale 1ns/1ps
`default_nettype none
module spsel_far
(
  // clock
  input wire logic clk_sys,
  // pin drivers
  input wire logic drv_out,
  input wire logic drv_oe,
  input wire logic ext_en,
  input wire logic ext_val,
  // resolved level
  output logic pin
);
  logic tog = 1'h0;
  // a released pin wanders instead of holding its last value
  always @(posedge clk_sys)
    tog <= ~tog;
  // device drive wins, else the outside source
  assign pin = drv_oe ? drv_out : (ext_en ? ext_val : tog);
endmodule : spsel_far
`default_nettype wire

// *** tb.sv ***
// self-checking testbench of the strobe and pattern pin select
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb;
  import spsel_pkg::*;
  logic clk_sys = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0, ext_val = 1'h0;
  logic gpio_b0_out = 1'h0, gpio_b0_oe = 1'h0, timer2_compare_a_out = 1'h0, timer2_compare_a_oe = 1'h0;
  logic chip_select_1_n = 1'h1, chip_select_3_n = 1'h1, column_strobe_high_n = 1'h1;
  logic column_strobe_low_n = 1'h1, port_b_bit0_in, port_b_bit0_out, port_b_bit0_oe, e_oe, e_out;
  logic gpio_b0_in, timer2_capture_a_in, strobe_hi_pin_n, strobe_lo_pin_n;
  logic [25:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, pattern_next_data = '0, pattern_out, r = 16'h003d, pe = '0, e;
  logic [3:0] group_compare_a = '0, group_compare_b = '0, s;
  logic [15:0] exp_q[$];
  int bad_count = 0, n_checks = 0;
  // design and far-side pin
  spsel_top dut (.*);
  spsel_far u_far (.clk_sys, .drv_out(port_b_bit0_out), .drv_oe(port_b_bit0_oe), .ext_en(1'h1),
    .ext_val, .pin(port_b_bit0_in));
  always #2.5 clk_sys = ~clk_sys;
  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lf
  task automatic wr(input logic [25:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [25:0] a, input logic [15:0] v);
    exp_q.push_back(v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
  endtask : rd
  // one compare pulse to all groups, expected pattern tracked in pe
  task automatic pulse(input logic a, input logic b, input logic nov);
    r = lf(r);
    @(posedge clk_sys);
    group_compare_a <= {4{a}};
    group_compare_b <= {4{b}};
    pattern_next_data <= r;
    pe = nov ? ((a ? pe | r : pe) & (b ? r : 16'hffff)) : (a ? r : pe);
    @(posedge clk_sys);
    group_compare_a <= 4'h0;
    group_compare_b <= 4'h0;
    #1;
    `CHK(pattern_out, pe)
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // read data compared against the oldest note
  always @(posedge clk_sys)
  begin
    if (rd_d)
    begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    rd_d <= reg_rd;
  end
  initial
  begin
    #20000;
    bad_count++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    rd(SPSEL_ADDR_STROBE_SEL, 16'h5fff);
    rd(SPSEL_ADDR_PATTERN_MODE, 16'h00f0);
    rd(SPSEL_ADDR_PORTB_CTRL2, 16'h0000);
    rd(26'h5ffffe0, 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      wr(SPSEL_ADDR_STROBE_SEL, {c[1:0], c[1:0], 12'h000});
      rd(SPSEL_ADDR_STROBE_SEL, {c[1:0], c[1:0], 12'hfff});
      for (int j = 0; j < 2; j++)
      begin
        r = lf(r);
        s = r[3:0] ^ {4{j[0]}};
        @(posedge clk_sys);
        {chip_select_1_n, chip_select_3_n, column_strobe_high_n, column_strobe_low_n} <= s;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(strobe_hi_pin_n, c == 1 ? s[3] : (c == 2 ? s[1] : 1'h1))
        `CHK(strobe_lo_pin_n, c == 1 ? s[2] : (c == 2 ? s[0] : 1'h1))
      end
    end
    pulse(1'h0, 1'h1, 1'h0);
    pulse(1'h1, 1'h0, 1'h0);
    wr(SPSEL_ADDR_PATTERN_MODE, 16'hffff);
    rd(SPSEL_ADDR_PATTERN_MODE, 16'h00ff);
    pulse(1'h1, 1'h0, 1'h1);
    pulse(1'h0, 1'h1, 1'h1);
    pulse(1'h1, 1'h1, 1'h1);
    for (int k = 0; k < 4; k++)
    begin
      r = lf(r);
      wr(SPSEL_ADDR_PORTB_CTRL2, {r[15:2], k[1:0]});
      rd(SPSEL_ADDR_PORTB_CTRL2, {14'h0000, k[1:0]});
      {gpio_b0_out, gpio_b0_oe, timer2_compare_a_out, timer2_compare_a_oe, ext_val} <= r[4:0];
      e_oe = k == 0 ? r[3] : (k == 2 ? r[1] : k == 3);
      e_out = k == 0 ? r[4] : (k == 2 ? r[2] : pe[0]);
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK(port_b_bit0_oe, e_oe)
      if (e_oe) `CHK(port_b_bit0_out, e_out)
      `CHK(gpio_b0_in, e_oe ? e_out : r[0])
      `CHK(timer2_capture_a_in, k == 2 ? (e_oe ? e_out : r[0]) : 1'h0)
    end
    repeat (2) @(posedge clk_sys);
    complete_run();
  end
endmodule : tb
`default_nettype wire
